// ===== src/mbx_pkg.sv
package mbx_pkg;
	localparam int MBX_NPAR = 16;
	localparam int MBX_DEPTH = 48;
	localparam int MBX_MAXQ = 16;
	localparam logic [7:0] FN_READ = 8'h03;
	localparam logic [7:0] FN_WR1 = 8'h06;
	localparam logic [7:0] FN_DIAG = 8'h08;
	localparam logic [7:0] FN_WRN = 8'h10;
	localparam logic [7:0] FN_EXC = 8'h80;
	localparam logic [7:0] EX_NONE = 8'h00;
	localparam logic [7:0] EX_CMD = 8'h01;
	localparam logic [7:0] EX_ADDR = 8'h02;
	localparam logic [7:0] EX_VALUE = 8'h03;
	localparam logic [7:0] EX_FAIL = 8'h04;
	localparam logic [7:0] EX_PWD = 8'h05;
	localparam logic [7:0] EX_FRAME = 8'h06;
	localparam logic [7:0] EX_RO = 8'h07;
	localparam logic [7:0] EX_RUN = 8'h08;
	localparam logic [7:0] EX_LOCK = 8'h09;
	localparam logic [15:0] CTRL_ADDR = 16'h2000;
	localparam logic [15:0] PWD_ADDR = 16'h2100;
	localparam logic [15:0] RUN_FWD = 16'h0001;
	localparam logic [15:0] RUN_REV = 16'h0002;
	localparam logic [15:0] RUN_STOP = 16'h0005;
	localparam logic [15:0] TERM_RESET_FN = 16'h0007;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [1:0] SRC_COMM = 2'h2;
	localparam logic [1:0] CHAN_MODBUS = 2'h0;
	localparam longint CLK_HZ = 250000000;
	localparam longint BAUD_DEF = 9600;
	localparam longint CHAR_BITS = 11;
	localparam longint T35_TENTHS = 35;
	localparam int MBX_T35_CYCLES = int'((T35_TENTHS * CHAR_BITS * CLK_HZ
		+ 10 * BAUD_DEF - 1) / (10 * BAUD_DEF));
	localparam logic [11:0] A_CFG = 12'h000;
	localparam logic [11:0] A_PWD = 12'h004;
	localparam logic [11:0] A_ROM = 12'h008;
	localparam logic [11:0] A_RLM = 12'h00c;
	localparam logic [11:0] A_STAT = 12'h010;
	localparam logic [11:0] A_PAR = 12'h040;
	localparam int CFG_STN_LSB = 0;
	localparam int CFG_BAUD_LSB = 8;
	localparam int CFG_FMT_LSB = 12;
	localparam int CFG_SRC_LSB = 16;
	localparam int CFG_CHAN_LSB = 18;
	localparam int CFG_LOCK_BIT = 20;
	localparam logic [7:0] STN_RST = 8'h01;
	typedef enum logic [2:0] {
		S_WAIT = 3'b000,
		S_LISTEN = 3'b001,
		S_RECV = 3'b011,
		S_CHK = 3'b010,
		S_WR = 3'b110,
		S_TX = 3'b111
	} mbx_state_t;
	typedef struct packed {
		logic [7:0] station;
		logic [3:0] baud;
		logic [3:0] fmt;
		logic [1:0] src;
		logic [1:0] chan;
		logic lock_en;
	} mbx_cfg_t;
	localparam mbx_cfg_t CFG_RST = '{STN_RST, 4'h0, 4'h0, 2'h0, 2'h0, 1'b0};
	typedef struct packed {
		mbx_state_t state;
		logic [23:0] gap;
		logic [5:0] len;
		logic ovf;
		logic rxerr;
		logic [15:0] crc;
		logic [MBX_DEPTH-1:0][7:0] buf_;
		logic [MBX_NPAR-1:0][15:0] par;
		mbx_cfg_t cfg;
		logic [15:0] pwd;
		logic [15:0] ro;
		logic [15:0] rl;
		logic unlocked;
		logic running;
		logic reverse;
		logic faulted;
		logic [7:0] fcode;
		logic [7:0] exc;
		logic [7:0] last_exc;
		logic [5:0] cnt;
		logic [5:0] txlen;
		logic [7:0] txd;
		logic keyp;
		logic [4:0] termp;
		logic [2:0] leds;
		logic [31:0] prdata;
		logic pslverr;
	} mbx_st_t;
	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
		begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction
	function automatic logic [3:0] term_idx(input int k);
		logic [3:0] t;
		t = (k == 4) ? 4'h9 : 4'(k + 1);
		return t;
	endfunction
endpackage

// ===== src/mbx_slave.sv
`timescale 1ns/1ps
// Operation
// - every rejected request gets an error reply
// - unsupported function code answers 01H
// - request while faulted answers 01H
// - address plus quantity out of space: 02H
// - bad count or byte total: 03H
// - invalid setting like duplicate terminal: 04H
// - wrong password at verify address: 05H
// - bad length or CRC answers 06H
// - read-only parameter write: unchanged, 07H
// - running-locked parameter while running: 08H
// - locked without password: reads, writes 09H
// - 0001H to 2000H runs forward
// - accepted single write echoed unchanged
// - run commands need comm source, Modbus
// - only own station address frames processed
// - fault lights three indicators, shows code
// - stop/reset key clears latched fault
// - terminal set to function 7 clears fault
// - frames framed by 3.5 character silence at 9600 baud, whatever the baud setting
module mbx_slave
	import mbx_pkg::*;
#(
	parameter int T35_CYCLES = MBX_T35_CYCLES
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_err,
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	input  wire logic        tx_ready,
	input  wire logic        fault_event,
	input  wire logic [7:0]  fault_code,
	input  wire logic        stop_reset_key,
	input  wire logic [4:0]  terminal_in,
	output logic             run_forward,
	output logic             run_reverse,
	output logic             run_tune_indicator,
	output logic             direction_indicator,
	output logic             local_remote_indicator,
	output logic [7:0]       fault_display,
	output logic [3:0]       baud_rate_setting,
	output logic [3:0]       character_format_setting
);

	mbx_st_t s;
	mbx_st_t n;

	// apb decode: 0 none, 1..5 fixed registers, 8 parameter window
	function automatic logic [3:0] reg_sel(input logic [11:0] ad);
		logic [3:0] r;
		r = 4'h0;
		if (ad == A_CFG)
			r = 4'h1;
		else if (ad == A_PWD)
			r = 4'h2;
		else if (ad == A_ROM)
			r = 4'h3;
		else if (ad == A_RLM)
			r = 4'h4;
		else if (ad == A_STAT)
			r = 4'h5;
		else if (ad >= A_PAR && ad < A_PAR + 12'(4 * MBX_NPAR)
			&& ad[1:0] == 2'b00)
			r = 4'h8;
		return r;
	endfunction

	logic [7:0]  fn;
	logic [15:0] a;
	logic [15:0] q;
	logic [7:0]  bc;
	logic [15:0] wa;
	logic [15:0] wv;
	logic [3:0]  pi;
	logic [5:0]  wi;
	logic [7:0]  hx;
	logic [7:0]  wx;
	logic        known;
	logic        lenbad;
	logic        locked;
	logic        silent;
	logic        gated;
	logic        dup;
	logic        isterm;
	logic        clr;
	logic        last;
	logic [16:0] aend;
	logic [3:0]  sel;
	logic [3:0]  ti;
	logic [15:0] crc_n;

	always_comb
	begin
		n = s;
		fn = s.buf_[1];
		a = {s.buf_[2], s.buf_[3]};
		q = {s.buf_[4], s.buf_[5]};
		bc = s.buf_[6];
		wa = a + {10'h000, s.cnt};
		wi = 6'(7) + {s.cnt[4:0], 1'b0};
		wv = (fn == FN_WRN) ? {s.buf_[wi], s.buf_[wi + 6'(1)]} : q;
		pi = wa[3:0];
		aend = {1'b0, a} + {1'b0, q};
		silent = s.gap >= 24'(T35_CYCLES);
		locked = s.cfg.lock_en & ~s.unlocked;
		gated = s.cfg.src == SRC_COMM && s.cfg.chan == CHAN_MODBUS;
		known = fn == FN_READ || fn == FN_WR1 || fn == FN_DIAG
			|| fn == FN_WRN;
		crc_n = s.crc;
		ti = 4'h0;
		sel = 4'h0;
		last = 1'b0;

		// frame level checks in descending priority, first match wins
		lenbad = s.ovf | s.rxerr | (s.len < 6'd4)
			| (known && fn != FN_WRN && s.len != 6'd8)
			| (fn == FN_WRN && {2'b00, s.len} != bc + 8'd9);
		hx = EX_NONE;
		if (lenbad || s.crc != 16'h0000)
			hx = EX_FRAME;
		else if (locked && !(fn == FN_WR1 && a == PWD_ADDR))
			hx = EX_LOCK;
		else if (!known)
			hx = EX_CMD;
		else if (s.faulted)
			hx = EX_CMD;
		else if (((fn == FN_READ || fn == FN_WRN)
			&& (q == 16'h0000 || q > 16'(MBX_MAXQ)))
			|| (fn == FN_WRN && {8'h00, bc} != {q[14:0], 1'b0})
			|| (fn == FN_DIAG && a != 16'h0000))
			hx = EX_VALUE;
		else if (((fn == FN_READ || fn == FN_WRN)
			&& aend > 17'(MBX_NPAR))
			|| (fn == FN_WR1 && a >= 16'(MBX_NPAR)
			&& a != CTRL_ADDR && a != PWD_ADDR))
			hx = EX_ADDR;

		// per word checks, all words before any is written
		isterm = 1'b0;
		dup = 1'b0;
		for (int k = 0; k < 5; k++)
		begin
			if (term_idx(k) == pi)
				isterm = 1'b1;
		end
		for (int k = 0; k < 5; k++)
		begin
			if (isterm && term_idx(k) != pi && wv != 16'h0000
				&& s.par[term_idx(k)] == wv)
				dup = 1'b1;
		end
		wx = EX_NONE;
		if (wa == PWD_ADDR)
			wx = (wv != s.pwd) ? EX_PWD : EX_NONE;
		else if (wa == CTRL_ADDR)
			wx = (wv == RUN_FWD || wv == RUN_REV || wv == RUN_STOP)
				? EX_NONE : EX_FAIL;
		else if (s.ro[pi])
			wx = EX_RO;
		else if (s.rl[pi] && s.running)
			wx = EX_RUN;
		else if (dup)
			wx = EX_FAIL;

		// apb: read data captured in setup, writes in access
		sel = reg_sel(paddr);
		if (psel && !penable)
		begin
			n.pslverr = sel == 4'h0;
			unique case (sel)
				4'h1: n.prdata = {11'h000, s.cfg.lock_en, s.cfg.chan,
					s.cfg.src, s.cfg.fmt, s.cfg.baud, s.cfg.station};
				4'h2: n.prdata = {16'h0000, s.pwd};
				4'h3: n.prdata = {16'h0000, s.ro};
				4'h4: n.prdata = {16'h0000, s.rl};
				4'h5: n.prdata = {8'h00, s.last_exc, s.fcode, 4'h0,
					s.unlocked, s.reverse, s.running, s.faulted};
				4'h8: n.prdata = {16'h0000, s.par[paddr[5:2]]};
				default: n.prdata = 32'h0000_0000;
			endcase
		end
		if (psel && penable && pwrite)
		begin
			unique case (sel)
				4'h1:
				begin
					n.cfg.station = pwdata[CFG_STN_LSB +: 8];
					n.cfg.baud = pwdata[CFG_BAUD_LSB +: 4];
					n.cfg.fmt = pwdata[CFG_FMT_LSB +: 4];
					n.cfg.src = pwdata[CFG_SRC_LSB +: 2];
					n.cfg.chan = pwdata[CFG_CHAN_LSB +: 2];
					n.cfg.lock_en = pwdata[CFG_LOCK_BIT];
					if (pwdata[CFG_LOCK_BIT])
						n.unlocked = 1'b0;
				end
				4'h2: n.pwd = pwdata[15:0];
				4'h3: n.ro = pwdata[15:0];
				4'h4: n.rl = pwdata[15:0];
				4'h8: n.par[paddr[5:2]] = pwdata[15:0];
				default: n.pwd = s.pwd;
			endcase
		end

		// line silence restarts on every character either way
		if (rx_valid || (s.state == S_TX && tx_ready))
			n.gap = 24'h000000;
		else if (!silent)
			n.gap = s.gap + 24'h000001;

		unique case (s.state)
			S_WAIT:
			begin
				if (silent && !rx_valid)
					n.state = S_LISTEN;
			end
			S_LISTEN:
			begin
				if (rx_valid)
				begin
					n.buf_[0] = rx_data;
					n.len = 6'd1;
					n.crc = crc_step(CRC_INIT, rx_data);
					n.ovf = 1'b0;
					n.rxerr = rx_err;
					n.state = S_RECV;
				end
			end
			S_RECV:
			begin
				if (rx_valid)
				begin
					if (s.len == 6'(MBX_DEPTH))
						n.ovf = 1'b1;
					else
					begin
						n.buf_[s.len] = rx_data;
						n.len = s.len + 6'd1;
					end
					n.crc = crc_step(s.crc, rx_data);
					n.rxerr = s.rxerr | rx_err;
				end
				else if (silent)
				begin
					n.state = S_CHK;
					n.cnt = 6'd0;
				end
			end
			S_CHK:
			begin
				if (s.buf_[0] != s.cfg.station)
					n.state = S_WAIT;
				else if (hx != EX_NONE)
				begin
					n.exc = hx;
					n.cnt = 6'd0;
					n.state = S_WR;
				end
				else if ((fn == FN_WR1 || fn == FN_WRN) && wx != EX_NONE)
				begin
					n.exc = wx;
					n.cnt = 6'd0;
					n.state = S_WR;
				end
				else if (fn == FN_WRN && s.cnt != q[5:0] - 6'd1)
					n.cnt = s.cnt + 6'd1;
				else
				begin
					n.exc = EX_NONE;
					n.cnt = 6'd0;
					n.state = S_WR;
				end
			end
			S_WR:
			begin
				if (s.exc != EX_NONE)
				begin
					n.buf_[1] = fn | FN_EXC;
					n.buf_[2] = s.exc;
					n.txlen = 6'd3;
					n.last_exc = s.exc;
					last = 1'b1;
				end
				else
				begin
					unique case (fn)
						FN_READ:
						begin
							n.buf_[2] = {q[6:0], 1'b0};
							// all words at once: they land on the header
							// bytes that name them
							for (int k = 0; k < MBX_MAXQ; k++)
								if (16'(k) < q)
									{n.buf_[3 + 2 * k], n.buf_[4 + 2 * k]} =
										s.par[pi + 4'(k)];
							n.txlen = 6'd3 + {q[4:0], 1'b0};
							last = 1'b1;
						end
						FN_WR1:
						begin
							if (wa == PWD_ADDR)
								n.unlocked = 1'b1;
							else if (wa == CTRL_ADDR)
							begin
								if (gated && !s.faulted)
								begin
									n.running = wv != RUN_STOP;
									n.reverse = wv == RUN_REV;
								end
							end
							else
								n.par[pi] = wv;
							n.txlen = 6'd6;
							last = 1'b1;
						end
						FN_WRN:
						begin
							n.par[pi] = wv;
							n.txlen = 6'd6;
							last = s.cnt == q[5:0] - 6'd1;
						end
						default:
						begin
							n.txlen = 6'd6;
							last = 1'b1;
						end
					endcase
				end
				if (last)
				begin
					n.cnt = 6'd0;
					n.crc = CRC_INIT;
					n.txd = s.buf_[0];
					n.state = S_TX;
				end
				else
					n.cnt = s.cnt + 6'd1;
			end
			S_TX:
			begin
				// crc is rebuilt while sending, so an echo repeats the
				// received check bytes exactly
				if (tx_ready)
				begin
					n.cnt = s.cnt + 6'd1;
					if (s.cnt < s.txlen)
					begin
						crc_n = crc_step(s.crc, s.buf_[s.cnt]);
						n.crc = crc_n;
						n.txd = (s.cnt + 6'd1 < s.txlen)
							? s.buf_[s.cnt + 6'd1] : crc_n[7:0];
					end
					else if (s.cnt == s.txlen)
						n.txd = s.crc[15:8];
					else
						n.state = S_WAIT;
				end
			end
			default: n.state = S_WAIT;
		endcase

		// fault latch: a new fault wins over a same-cycle reset
		clr = stop_reset_key & ~s.keyp;
		for (int k = 0; k < 5; k++)
		begin
			ti = term_idx(k);
			if (terminal_in[k] && !s.termp[k]
				&& s.par[ti] == TERM_RESET_FN)
				clr = 1'b1;
		end
		n.keyp = stop_reset_key;
		n.termp = terminal_in;
		if (fault_event)
		begin
			n.faulted = 1'b1;
			n.fcode = fault_code;
			n.running = 1'b0;
		end
		else if (clr)
			n.faulted = 1'b0;
		n.leds = n.faulted ? 3'b111
			: {n.cfg.src == SRC_COMM, n.reverse, n.running};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s <= '0;
			s.state <= S_WAIT;
			s.cfg <= CFG_RST;
		end
		else
			s <= n;
	end

	// zero wait states: read data was captured in the setup cycle
	assign pready = 1'b1;
	assign prdata = s.prdata;
	assign pslverr = s.pslverr;
	assign tx_valid = s.state == S_TX && s.cnt <= s.txlen + 6'd1;
	assign tx_data = s.txd;
	assign run_forward = s.running & ~s.reverse;
	assign run_reverse = s.running & s.reverse;
	assign run_tune_indicator = s.leds[0];
	assign direction_indicator = s.leds[1];
	assign local_remote_indicator = s.leds[2];
	assign fault_display = s.faulted ? s.fcode : 8'h00;
	// the uart outside takes these; the master must match them
	assign baud_rate_setting = s.cfg.baud;
	assign character_format_setting = s.cfg.fmt;

endmodule // mbx_slave

// ===== verif/mbx_slave_properties.sv
`timescale 1ns/1ps
module mbx_slave_chk
	import mbx_pkg::*;
#(
	parameter int T35_CYCLES = MBX_T35_CYCLES
)(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pslverr,
	input wire logic        rx_valid,
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_data,
	input wire logic        tx_ready,
	input wire logic        fault_event,
	input wire logic [7:0]  fault_code,
	input wire logic        stop_reset_key,
	input wire logic        run_forward,
	input wire logic        run_reverse,
	input wire logic        run_tune_indicator,
	input wire logic        direction_indicator,
	input wire logic        local_remote_indicator,
	input wire logic [7:0]  fault_display
);
	logic [23:0] quiet_reg;
	logic [7:0]  code_reg;
	logic        mapped;
	assign mapped = paddr[1:0] == 2'h0 && (paddr <= 12'h010
		|| (paddr >= 12'h040 && paddr <= 12'h07c));
	// saturating, so a long idle never wraps into a false gap
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			quiet_reg <= 24'h0;
			code_reg <= 8'h00;
		end
		else
		begin
			if (rx_valid)
				quiet_reg <= 24'h0;
			else if (quiet_reg < 24'(T35_CYCLES))
				quiet_reg <= quiet_reg + 24'h1;
			if (fault_event)
				code_reg <= fault_code;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_lit;
		run_tune_indicator && direction_indicator && local_remote_indicator;
	endsequence
	sequence s_halted;
		!run_forward && !run_reverse;
	endsequence
	a_err_unmapped: assert property (
		psel && !penable |=> pslverr == !$past(mapped))
		else $error("pslverr does not follow the map");
	a_reply_gap: assert property (
		$rose(tx_valid) |-> quiet_reg >= 24'(T35_CYCLES))
		else $error("reply started without line silence");
	a_tx_hold: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("reply byte changed before accept");
	a_tx_end: assert property (
		$fell(tx_valid) |-> $past(tx_ready))
		else $error("reply byte withdrawn");
	a_fault_lights: assert property (
		fault_event |-> ##[1:3] s_lit)
		else $error("fault indicators not lit");
	a_fault_code: assert property (
		fault_event |-> ##[1:3] fault_display == code_reg)
		else $error("fault code not shown");
	a_lit_hold: assert property (
		fault_display != 8'h00 |-> ##[0:1] s_lit)
		else $error("fault shown without indicators");
	a_fault_stop: assert property (
		fault_event |-> ##[1:3] s_halted)
		else $error("fault did not stop the run");
	a_key_clear: assert property (
		$rose(stop_reset_key) && !fault_event
		|-> ##[1:3] fault_display == 8'h00)
		else $error("key did not clear fault");
endmodule // mbx_slave_chk

bind mbx_slave mbx_slave_chk #(.T35_CYCLES(T35_CYCLES)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .pslverr(pslverr), .rx_valid(rx_valid),
	.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
	.fault_event(fault_event), .fault_code(fault_code),
	.stop_reset_key(stop_reset_key), .run_forward(run_forward),
	.run_reverse(run_reverse), .run_tune_indicator(run_tune_indicator),
	.direction_indicator(direction_indicator),
	.local_remote_indicator(local_remote_indicator),
	.fault_display(fault_display)
);

// ===== verif/mbx_master.sv
`timescale 1ns/1ps
module mbx_master
(
	input  wire logic       pclk,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_err,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	logic [7:0] got[$];
	logic       slow;
	logic       garble;
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_err = 1'b0;
		tx_ready = 1'b0;
		slow = 1'b0;
		garble = 1'b0;
	end
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i])
		begin
			c = c ^ {8'h00, q[i]};
			for (int b = 0; b < 8; b++)
				c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction
	// character framing lives in the uart; bytes arrive clean unless garble sets rx_err
	task automatic send(input logic [7:0] q[$], input logic bad);
		logic [15:0] c;
		c = crc16(q) ^ {15'h0, bad};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		got.delete();
		foreach (q[i])
		begin
			@(posedge pclk);
			rx_valid <= 1'b1;
			rx_err <= garble;
			rx_data <= q[i];
			@(posedge pclk);
			rx_valid <= 1'b0;
			rx_err <= 1'b0;
			rx_data <= ~q[i];
			repeat (3) @(posedge pclk);
		end
	endtask
	always @(posedge pclk)
	begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end
endmodule // mbx_master

// ===== verif/modbus_slave_exception_and_fault_reset_tb.sv
`timescale 1ns/1ps
module modbus_slave_exception_and_fault_reset_tb
	import mbx_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        rx_valid, rx_err, tx_valid, tx_ready, fault_event;
	logic [7:0]  rx_data, tx_data, fault_code, fault_display;
	logic        stop_reset_key, run_forward, run_reverse;
	logic [4:0]  terminal_in;
	logic        rt_ind, dir_ind, lr_ind;
	logic [3:0]  baud_rate_setting, character_format_setting;
	int          fail_count;
	int          num_checks;
	mbx_slave #(.T35_CYCLES(50)) u_dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .rx_valid, .rx_data, .rx_err,
		.tx_valid, .tx_data, .tx_ready, .fault_event, .fault_code,
		.stop_reset_key, .terminal_in, .run_forward, .run_reverse,
		.run_tune_indicator(rt_ind), .direction_indicator(dir_ind),
		.local_remote_indicator(lr_ind), .fault_display,
		.baud_rate_setting, .character_format_setting
	);
	mbx_master u_mst (
		.pclk, .rx_valid, .rx_data, .rx_err, .tx_valid, .tx_data, .tx_ready
	);
	always #2 pclk = ~pclk;
	task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [32:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = {pslverr, prdata};
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [32:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] x);
		logic [32:0] r;
		apb(1'b0, a, 32'h0, r);
		cmp(r, x);
	endtask
	task automatic xact(input logic [87:0] f, input logic [87:0] x,
		input int n, input logic bad, input int m = 6);
		logic [7:0]  q[$];
		logic [7:0]  e[$];
		logic [15:0] c;
		for (int i = 0; i < m; i++)
			q.push_back(f[8*m-1-8*i -: 8]);
		for (int i = 0; i < n; i++)
			e.push_back(x[8*n-1-8*i -: 8]);
		c = u_mst.crc16(e);
		if (n > 0)
		begin
			e.push_back(c[7:0]);
			e.push_back(c[15:8]);
		end
		u_mst.send(q, bad);
		for (int k = 0; k < 300; k++)
		begin
			if (n > 0 && u_mst.got.size() >= e.size())
				break;
			@(posedge pclk);
		end
		cmp(u_mst.got.size(), e.size());
		foreach (e[i])
			cmp(u_mst.got[i], e[i]);
		tick(60);
	endtask
	task automatic ex(input logic [47:0] f, input logic [7:0] code);
		xact(f, {8'h03, f[39:32] | 8'h80, code}, 3, 1'b0);
	endtask
	task automatic hit(input logic [7:0] c);
		@(posedge pclk);
		fault_event <= 1'b1;
		fault_code <= c;
		@(posedge pclk);
		fault_event <= 1'b0;
		tick(3);
		cmp({fault_display, rt_ind, dir_ind, lr_ind}, {c, 3'b111});
	endtask
	task automatic t_regs;
		rd(A_CFG, 33'h000000001);
		rd(12'h020, 33'h100000000);
		wr(A_CFG, 32'h00003503);
		tick(2);
		cmp({baud_rate_setting, character_format_setting}, 8'h53);
	endtask
	task automatic t_gate;
		xact(48'h030620000001, 48'h030620000001, 6, 1'b0);
		cmp(run_forward, 1'b0);
		wr(A_CFG, 32'h00023503);
		u_mst.slow <= 1'b1;
		xact(48'h030620000001, 48'h030620000001, 6, 1'b0);
		cmp({run_forward, rt_ind}, 2'b11);
		xact(48'h050620000005, 48'h0, 0, 1'b0);
		cmp(run_forward, 1'b1);
		xact(48'h030620000002, 48'h030620000002, 6, 1'b0);
		cmp({run_forward, run_reverse, dir_ind}, 3'b011);
	endtask
	task automatic t_rej;
		wr(A_RLM, 32'h2);
		ex(48'h030600010003, 8'h08);
		xact(48'h030620000005, 48'h030620000005, 6, 1'b0);
		cmp({run_forward, run_reverse}, 2'b00);
		wr(A_PAR, 32'h55);
		wr(A_ROM, 32'h1);
		ex(48'h030600000009, 8'h07);
		rd(A_PAR, 33'h55);
		wr(A_PAR + 12'h004, 32'h7);
		ex(48'h030600020007, 8'h04);
		ex(48'h030620000003, 8'h04);
		ex(48'h030500000001, 8'h01);
		ex(48'h0303000f0002, 8'h02);
		ex(48'h030300000000, 8'h03);
		ex(48'h030800011234, 8'h03);
		xact(48'h0308000012ab, 48'h0308000012ab, 6, 1'b0);
		xact(88'h0310000400020413880032, 48'h031000040002, 6, 1'b0,
			11);
		xact(48'h030300040002, 56'h03030413880032, 7, 1'b0);
		xact(48'h030300000001, 24'h038306, 3, 1'b1);
		u_mst.garble <= 1'b1;
		ex(48'h030300000001, 8'h06);
		u_mst.garble <= 1'b0;
	endtask
	task automatic t_pwd;
		wr(A_PWD, 32'h1234);
		ex(48'h030621001111, 8'h05);
		wr(A_CFG, 32'h00123503);
		ex(48'h030300010001, 8'h09);
		ex(48'h030600050001, 8'h09);
		xact(48'h030621001234, 48'h030621001234, 6, 1'b0);
		xact(48'h030300010001, 40'h0303020007, 5, 1'b0);
	endtask
	task automatic t_fault;
		xact(48'h030620000001, 48'h030620000001, 6, 1'b0);
		hit(8'h11);
		cmp(run_forward, 1'b0);
		ex(48'h030300010001, 8'h01);
		rd(A_STAT, 33'h000011109);
		stop_reset_key <= 1'b1;
		tick(4);
		cmp(fault_display, 8'h00);
		stop_reset_key <= 1'b0;
		hit(8'h2a);
		terminal_in <= 5'h01;
		tick(4);
		cmp({fault_display, rt_ind, dir_ind, lr_ind}, 11'h001);
		terminal_in <= 5'h00;
	endtask
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		fault_event = 1'b0;
		fault_code = 8'h00;
		stop_reset_key = 1'b0;
		terminal_in = 5'h00;
		fail_count = 0;
		num_checks = 0;
		tick(12);
		presetn <= 1'b1;
		tick(60);
		t_regs;
		t_gate;
		t_rej;
		t_pwd;
		t_fault;
		close_out;
	end
	initial
	begin
		tick(20000);
		fail_count++;
		close_out;
	end
endmodule // modbus_slave_exception_and_fault_reset_tb
